/* verilog/psd_sequencer.sv */
// Power-down, reset and termination timing sequencer of the memory device
//
// Overview of operation
// - Termination stays off during the 200-cycle DLL relock; ready afterwards.
// - Forced reset loses contents; device works again after reinitialisation.
// - During reset every input except CKE is ignored; an ODT edge still clears termAsyncTiming.
// - A read burst cut by reset may finish when CKE returns high.
// - Termination acts only after enable load plus mode update delay.
// - Termination timing follows CKE state; no switching in self refresh.
// - CKE high or fast-exit active power-down uses synchronous delays.
// - Slow-exit or precharge power-down uses asynchronous power-down timing.
// - Turn-off before entry is synchronous only if it precedes entry enough.
// - Turn-on before entry is synchronous only if it precedes entry enough.
// - Turn-off after any power-down is synchronous once exit latency passed.
// - Turn-on after slow or precharge power-down waits exit latency likewise.
// - Change to entry spacing for synchronous timing is three cycles.
// - Exit to change spacing for synchronous timing is eight cycles.
`timescale 1ns/1ps
module psd_sequencer
  import psd_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ckePin,
  input  wire logic odtPin,
  input  wire logic odtEnableLoad,
  input  wire logic odtEnableValue,
  input  wire logic slowExitBit,
  input  wire logic bankOpen,
  input  wire logic selfRefreshCmd,
  input  wire logic cmdNotNop,
  input  wire logic burstActive,
  input  wire logic readBurst,
  input  wire logic dllResetCmd,
  input  wire logic initDone,
  output logic      termOn,
  output logic      termAsyncTiming,
  output logic      powerDown,
  output logic      inReset,
  output logic      contentsLost,
  output logic      dllReady,
  output logic      burstResume
);
  localparam logic [CNT_W-1:0] ANPD_C   = CNT_W'(ANPD_CYC);
  localparam logic [CNT_W-1:0] AXPD_C   = CNT_W'(AXPD_CYC);
  localparam logic [CNT_W-1:0] MOD_C    = CNT_W'(MOD_CYC);
  localparam logic [CNT_W-1:0] RELOCK_C = CNT_W'(DLL_RELOCK_CYC);
  localparam logic [1:0]       AOND_C   = 2'(AOND_CYC);
  localparam logic [1:0]       AOFD_C   = 2'(AOFD_CYC);

  typedef struct packed {
    logic [1:0] ckeSync;     // [0] first stage, [1] second stage
    logic [1:0] odtSync;
    logic       ckePrev;
    logic       odtPrev;
    psd_state_e state;
    logic       pdAsync;     // Current power-down uses asynchronous timing
    logic       exitAsync;   // Last exit was slow-exit or precharge
    logic       exitAny;     // Some power-down has been left
    logic       odtEnabled;
    logic       relocking;
    logic       pendValid;
    logic       pendLevel;
    logic [1:0] pendCnt;
    logic       termOn;
    logic       termAsync;
    logic       lost;
    logic       readCut;
    logic       resume;
    logic       pdFlag;      // Registered copies of the status outputs
    logic       rstFlag;
    logic       dllLocked;
  } psd_st_s;

  psd_st_s          st_r;
  psd_st_s          st_nxt;
  logic [CNT_W-1:0] sinceCke;
  logic [CNT_W-1:0] sinceOdt;
  logic [CNT_W-1:0] sinceMod;
  logic [CNT_W-1:0] sinceDll;
  logic             ckeS;
  logic             odtS;
  logic             ckeFall;
  logic             ckeRise;
  logic             odtEdge;
  logic             allowed;

  // ==========================================================
  // Pin edges, seen only through the second synchroniser stage
  assign ckeS    = st_r.ckeSync[1];
  assign odtS    = st_r.odtSync[1];
  assign ckeFall = st_r.ckePrev & ~ckeS;
  assign ckeRise = ~st_r.ckePrev & ckeS;
  assign odtEdge = st_r.odtPrev ^ odtS;

  // ==========================================================
  // Cycle counters since the timing reference events
  psd_cycle_count #(.W(CNT_W)) u_sinceCke (
    .clk(clk), .resetn(resetn), .clear(ckeFall | ckeRise), .count(sinceCke));
  psd_cycle_count #(.W(CNT_W)) u_sinceOdt (
    .clk(clk), .resetn(resetn), .clear(odtEdge), .count(sinceOdt));
  psd_cycle_count #(.W(CNT_W)) u_sinceMod (
    .clk(clk), .resetn(resetn), .clear(odtEnableLoad & (st_r.state != PSD_RESET)),
    .count(sinceMod));
  psd_cycle_count #(.W(CNT_W)) u_sinceDll (
    .clk(clk), .resetn(resetn), .clear(dllResetCmd & (st_r.state == PSD_ACTIVE)),
    .count(sinceDll));

  // Termination may act only when enabled, settled, locked and not in self refresh
  assign allowed = st_r.odtEnabled && (sinceMod >= MOD_C)
                   && !st_r.relocking
                   && (st_r.state == PSD_ACTIVE || st_r.state == PSD_PDOWN);

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.ckeSync = {st_r.ckeSync[0], ckePin};
    st_nxt.odtSync = {st_r.odtSync[0], odtPin};
    st_nxt.ckePrev = ckeS;
    st_nxt.odtPrev = odtS;
    st_nxt.resume  = 1'b0;

    // Operating state follows the registered CKE level
    case (st_r.state)
      PSD_ACTIVE: begin
        if (ckeFall) begin
          if (selfRefreshCmd) begin
            st_nxt.state = PSD_SREF;
          end else if (cmdNotNop || burstActive) begin
            // Illegal entry: treated as the forced reset
            st_nxt.state   = PSD_RESET;
            st_nxt.lost    = 1'b1;
            st_nxt.readCut = burstActive & readBurst;
          end else begin
            st_nxt.state   = PSD_PDOWN;
            st_nxt.pdAsync = ~bankOpen | slowExitBit;
          end
        end
      end
      PSD_PDOWN: begin
        if (ckeRise) begin
          st_nxt.state     = PSD_ACTIVE;
          st_nxt.exitAsync = st_r.pdAsync;
          st_nxt.exitAny   = 1'b1;
          // Precharge exit may follow a clock change: demand a DLL reset
          if (!bankOpen) begin
            st_nxt.relocking = 1'b1;
          end
        end
      end
      PSD_SREF: begin
        if (ckeRise) begin
          st_nxt.state = PSD_ACTIVE;
        end
      end
      PSD_RESET: begin
        // Nothing but CKE is looked at here
        if (ckeRise) begin
          st_nxt.state      = PSD_ACTIVE;
          st_nxt.odtEnabled = 1'b0;
          st_nxt.relocking  = 1'b1;
          st_nxt.resume     = st_r.readCut;
          st_nxt.readCut    = 1'b0;
        end
      end
      default: begin
        st_nxt.state = PSD_RESET;
      end
    endcase

    // Mode loads and DLL relock, honoured only outside reset
    if (st_r.state != PSD_RESET) begin
      if (odtEnableLoad) begin
        st_nxt.odtEnabled = odtEnableValue;
      end
      // A precharge exit in the same cycle demands a fresh DLL reset, so it wins
      if (st_r.relocking && sinceDll == RELOCK_C && !dllResetCmd
          && !(ckeRise && st_r.state == PSD_PDOWN && !bankOpen)) begin
        st_nxt.relocking = 1'b0;
      end
      if (dllResetCmd) begin
        st_nxt.relocking = 1'b1;
      end
      // A forced reset in the same cycle wins over the clear
      if (initDone && st_nxt.state != PSD_RESET) begin
        st_nxt.lost = 1'b0;
      end
    end

    // Termination timing category for each level change
    if (odtEdge) begin
      if (st_r.state == PSD_PDOWN && st_r.pdAsync) begin
        st_nxt.pendValid = 1'b0;
        st_nxt.termOn    = odtS;
        st_nxt.termAsync = 1'b1;
      end else if (st_r.state == PSD_ACTIVE && st_r.exitAny && sinceCke < AXPD_C
                   && (!odtS || st_r.exitAsync)) begin
        st_nxt.pendValid = 1'b0;
        st_nxt.termOn    = odtS;
        st_nxt.termAsync = 1'b1;
      end else begin
        st_nxt.pendValid = 1'b1;
        st_nxt.pendLevel = odtS;
        st_nxt.pendCnt   = odtS ? AOND_C : AOFD_C;
        st_nxt.termAsync = 1'b0;
      end
    end else if (st_r.pendValid) begin
      if (ckeFall && sinceOdt < ANPD_C && st_r.state == PSD_ACTIVE) begin
        // Entry came too soon after the change: finish it asynchronously
        st_nxt.pendValid = 1'b0;
        st_nxt.termOn    = st_r.pendLevel;
        st_nxt.termAsync = 1'b1;
      end else if (st_r.pendCnt == 2'h1) begin
        st_nxt.pendValid = 1'b0;
        st_nxt.termOn    = st_r.pendLevel;
      end else begin
        st_nxt.pendCnt = st_r.pendCnt - 2'h1;
      end
    end

    // Termination forced off whenever it may not act
    if (!allowed) begin
      st_nxt.termOn    = 1'b0;
      st_nxt.pendValid = 1'b0;
    end

    // Status taken from the next state, so the output flops add no lag
    st_nxt.pdFlag    = (st_nxt.state == PSD_PDOWN);
    st_nxt.rstFlag   = (st_nxt.state == PSD_RESET);
    st_nxt.dllLocked = ~st_nxt.relocking;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{ckeSync: SYNC_RST, odtSync: SYNC_RST, state: PSD_RESET,
                pendCnt: 2'h0, rstFlag: 1'b1, dllLocked: 1'b1, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs, straight from the state register
  assign termOn          = st_r.termOn;
  assign termAsyncTiming = st_r.termAsync;
  assign powerDown       = st_r.pdFlag;
  assign inReset         = st_r.rstFlag;
  assign contentsLost    = st_r.lost;
  assign dllReady        = st_r.dllLocked;
  assign burstResume     = st_r.resume;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_term_sref_off: assert property (
    (st_r.state == PSD_SREF) |=> !termOn)
    else $error("termination on in self refresh");
  chk_term_relock_off: assert property (
    $past(st_r.relocking) |-> !termOn)
    else $error("termination on during relock");
  chk_relock_length: assert property (
    (dllResetCmd && st_r.state == PSD_ACTIVE) |=> !dllReady [*8])
    else $error("dll ready too early after reset command");
  chk_sync_turn_on: assert property (
    (odtEdge && odtS && st_r.state == PSD_ACTIVE && !st_r.exitAny && allowed
     && !ckeFall && sinceMod > MOD_C) ##1 (allowed && !ckeFall && !odtEdge) [*2]
    |=> termOn)
    else $error("synchronous turn-on delay wrong");
  chk_async_pd_on: assert property (
    (odtEdge && st_r.state == PSD_PDOWN && st_r.pdAsync && allowed) |=> termOn == $past(odtS))
    else $error("power-down turn-on not immediate");
  chk_entry_flush: assert property (
    (st_r.pendValid && !odtEdge && ckeFall && sinceOdt < ANPD_C && allowed
     && st_r.state == PSD_ACTIVE) |=> (!st_r.pendValid && termAsyncTiming))
    else $error("late change not flushed at entry");
  chk_reset_lost: assert property (
    (st_r.state == PSD_ACTIVE && ckeFall && !selfRefreshCmd && (cmdNotNop || burstActive))
    |=> (inReset && contentsLost))
    else $error("forced reset not taken");
  chk_reset_ignores: assert property (
    (inReset && !ckeRise) |=> ($stable(st_r.odtEnabled) && inReset))
    else $error("input honoured during reset");
  chk_exit_async: assert property (
    (odtEdge && st_r.state == PSD_ACTIVE && st_r.exitAny && sinceCke < AXPD_C && !odtS)
    |=> (termAsyncTiming && !st_r.pendValid))
    else $error("early turn-off after exit not asynchronous");

  cov_pd_entry:   cover property (ckeFall ##1 powerDown);
  cov_reset_path: cover property (inReset ##[1:20] burstResume);
  cov_sync_on:    cover property (odtEdge && odtS ##3 termOn);
  cov_relock:     cover property (!dllReady ##1 dllReady);
endmodule // psd_sequencer

/* include/psd_pkg.sv */
// Constants and types for the power-down and termination sequencer
package psd_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS    = 40000;  // 25 MHz
  localparam int T_MOD_PS         = 12000;  // Mode update delay
  localparam int MOD_RAW          = (T_MOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MOD_CYC          = (MOD_RAW < 1) ? 1 : MOD_RAW;
  localparam int DLL_RELOCK_CYC   = 200;    // DLL relock interval, cycles
  localparam int ANPD_CYC         = 3;      // Change to power-down entry latency
  localparam int AXPD_CYC         = 8;      // Power-down exit to change latency
  localparam int AOND_CYC         = 2;      // Synchronous turn-on delay
  localparam int AOFD_CYC         = 3;      // Synchronous turn-off, 2.5 rounded up
  localparam int CNT_W            = 8;      // Width of the cycle counters
  localparam logic [1:0] SYNC_RST = 2'h0;

  // ==========================================================
  // Device operating state
  typedef enum logic [1:0] {
    PSD_ACTIVE = 2'b00,
    PSD_PDOWN  = 2'b01,
    PSD_SREF   = 2'b10,
    PSD_RESET  = 2'b11
  } psd_state_e;
endpackage

/* verilog/psd_cycle_count.sv */
// Saturating count of cycles since the last clear
`timescale 1ns/1ps
module psd_cycle_count #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clear,
  output logic [W-1:0]      count
);
  localparam logic [W-1:0] ALL_ONES = {W{1'b1}};
  localparam logic [W-1:0] ONE      = {{(W-1){1'b0}}, 1'b1};

  // ==========================================================
  // Counter; saturates so a long idle never wraps into a short one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= ALL_ONES;
    end else if (clear) begin
      count <= '0;
    end else if (count != ALL_ONES) begin
      count <= count + ONE;
    end
  end
endmodule // psd_cycle_count

/* verification/psd_ctrl_model.sv */
// Memory controller model that drives the device pins
`timescale 1ns/1ps
module psd_ctrl_model (
  input  wire logic clk,
  output logic      ckePin,
  output logic      odtPin,
  output logic      odtEnableLoad,
  output logic      odtEnableValue,
  output logic      slowExitBit,
  output logic      bankOpen,
  output logic      selfRefreshCmd,
  output logic      cmdNotNop,
  output logic      burstActive,
  output logic      readBurst,
  output logic      dllResetCmd,
  output logic      initDone
);
  // ==========================================
  // Pin levels at time zero
  initial begin
    {ckePin, odtPin, odtEnableLoad, odtEnableValue, slowExitBit, bankOpen} = '0;
    {selfRefreshCmd, cmdNotNop, burstActive, readBurst, dllResetCmd, initDone} = '0;
  end

  // ==========================================
  // Pin tasks, all moving one unit after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Level held for three registering edges before anything else moves
  task automatic cke(input logic v);
    ckePin = v;
    cyc(3);
  endtask

  task automatic set_odt(input logic v);
    odtPin = v;
  endtask

  task automatic set_mode(input logic bo, input logic se, input logic sr);
    bankOpen = bo;
    slowExitBit = se;
    selfRefreshCmd = sr;
  endtask

  // A cut read burst makes the next fall a forced reset
  task automatic set_cut(input logic v);
    burstActive = v;
    readBurst = v;
    cmdNotNop = v;
  endtask

  // Pulses; chained pulses drive different signals, so no signal moves twice at once
  task automatic load(input logic v);
    odtEnableLoad = 1'b1;
    odtEnableValue = v;
    cyc(1);
    odtEnableLoad = 1'b0;
  endtask

  task automatic pulse_dll();
    dllResetCmd = 1'b1;
    cyc(1);
    dllResetCmd = 1'b0;
  endtask

  task automatic pulse_init();
    initDone = 1'b1;
    cyc(1);
    initDone = 1'b0;
  endtask

  // Park in precharge power-down, termination off, before a clock change
  task automatic freq_park();
    odtPin = 1'b0;
    bankOpen = 1'b0;
    cyc(3);
    ckePin = 1'b0;
    cyc(3);
  endtask
endmodule // psd_ctrl_model

/* verification/psd_sequencer_tb.sv */
// Self-checking bench for the power-down and termination sequencer
`timescale 1ns/1ps
module psd_sequencer_tb;
  // ==========================================
  // Clock, reset and wiring
  realtime   halfPer = 20.0;
  logic      clk = 1'b0;
  logic      resetn = 1'b0;
  int        errors = 0;
  int        numChecks = 0;
  int        cycles = 0;
  wire logic ckePin, odtPin, odtEnableLoad, odtEnableValue, slowExitBit, bankOpen;
  wire logic selfRefreshCmd, cmdNotNop, burstActive, readBurst, dllResetCmd, initDone;
  wire logic termOn, termAsyncTiming, powerDown, inReset, contentsLost, dllReady, burstResume;

  // Half period is a variable so the clock can change rate mid-run
  always #(halfPer) clk = ~clk;

  psd_ctrl_model ctl_u (
    .clk(clk), .ckePin(ckePin), .odtPin(odtPin), .odtEnableLoad(odtEnableLoad),
    .odtEnableValue(odtEnableValue), .slowExitBit(slowExitBit), .bankOpen(bankOpen),
    .selfRefreshCmd(selfRefreshCmd), .cmdNotNop(cmdNotNop), .burstActive(burstActive),
    .readBurst(readBurst), .dllResetCmd(dllResetCmd), .initDone(initDone));
  psd_sequencer dut_u (
    .clk(clk), .resetn(resetn), .ckePin(ckePin), .odtPin(odtPin),
    .odtEnableLoad(odtEnableLoad), .odtEnableValue(odtEnableValue),
    .slowExitBit(slowExitBit), .bankOpen(bankOpen), .selfRefreshCmd(selfRefreshCmd),
    .cmdNotNop(cmdNotNop), .burstActive(burstActive), .readBurst(readBurst),
    .dllResetCmd(dllResetCmd), .initDone(initDone), .termOn(termOn),
    .termAsyncTiming(termAsyncTiming), .powerDown(powerDown), .inReset(inReset),
    .contentsLost(contentsLost), .dllReady(dllReady), .burstResume(burstResume));

  // ==========================================
  // Reporting
  task automatic chk(input string nm, input logic exp, input logic got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Ceiling far above the roughly 1000 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  // ==========================================
  // Scenarios
  task automatic relock();
    ctl_u.pulse_dll();
    // Tight bounds: still relocking 200 cycles after the command, ready one later
    ctl_u.cyc(200);
    chk("dllReady early", 1'b0, dllReady);
    ctl_u.cyc(1);
    chk("dllReady", 1'b1, dllReady);
  endtask

  // Synchronous turn-on after two more edges, turn-off after three
  task automatic t_sync();
    ctl_u.set_odt(1'b1);
    ctl_u.cyc(4);
    chk("termOn early", 1'b0, termOn);
    ctl_u.cyc(1);
    chk("termOn", 1'b1, termOn);
    chk("termAsyncTiming", 1'b0, termAsyncTiming);
    ctl_u.set_odt(1'b0);
    ctl_u.cyc(5);
    chk("termOn hold", 1'b1, termOn);
    ctl_u.cyc(1);
    chk("termOn off", 1'b0, termOn);
    ctl_u.cyc(4);
  endtask

  task automatic t_boot();
    ctl_u.cyc(1);
    chk("inReset", 1'b1, inReset);
    chk("termOn reset", 1'b0, termOn);
    chk("dllReady reset", 1'b1, dllReady);
    ctl_u.cke(1'b1);
    chk("inReset exit", 1'b0, inReset);
    chk("dllReady exit", 1'b0, dllReady);
    ctl_u.load(1'b1);
    ctl_u.set_odt(1'b1);
    ctl_u.cyc(8);
    chk("termOn relock", 1'b0, termOn);
    ctl_u.set_odt(1'b0);
    relock();
  endtask

  task automatic t_enable();
    ctl_u.load(1'b0);
    ctl_u.set_odt(1'b1);
    ctl_u.cyc(8);
    chk("termOn disabled", 1'b0, termOn);
    ctl_u.set_odt(1'b0);
    ctl_u.load(1'b1);
    ctl_u.cyc(2);
    t_sync();
  endtask

  // Turn-on inside power-down, then turn-off inside the exit window
  task automatic t_pd(input logic bo, input logic se, input logic as);
    ctl_u.set_mode(bo, se, 1'b0);
    ctl_u.cke(1'b0);
    chk("powerDown", 1'b1, powerDown);
    ctl_u.set_odt(1'b1);
    ctl_u.cyc(as ? 2 : 4);
    chk("termOn pd early", 1'b0, termOn);
    ctl_u.cyc(1);
    chk("termOn pd", 1'b1, termOn);
    chk("termAsyncTiming pd", as, termAsyncTiming);
    ctl_u.cke(1'b1);
    chk("powerDown exit", 1'b0, powerDown);
    ctl_u.set_odt(1'b0);
    ctl_u.cyc(2);
    if (bo) begin
      chk("termOn exit early", 1'b1, termOn);
      ctl_u.cyc(1);
      chk("termOn exit", 1'b0, termOn);
      chk("termAsyncTiming exit", 1'b1, termAsyncTiming);
      // Turn-on inside the exit window: immediate only after a slow exit
      ctl_u.set_odt(1'b1);
      ctl_u.cyc(3);
      chk("termOn exit on", se, termOn);
      chk("termAsyncTiming exit on", se, termAsyncTiming);
      ctl_u.set_odt(1'b0);
    end
    ctl_u.cyc(10);
  endtask

  // Turn-on one cycle before entry; fast exit would otherwise be synchronous
  task automatic t_entry();
    ctl_u.set_mode(1'b1, 1'b0, 1'b0);
    ctl_u.set_odt(1'b1);
    ctl_u.cyc(1);
    ctl_u.cke(1'b0);
    chk("termOn entry", 1'b1, termOn);
    chk("termAsyncTiming entry", 1'b1, termAsyncTiming);
    ctl_u.cke(1'b1);
    ctl_u.set_odt(1'b0);
    ctl_u.cyc(12);
  endtask

  task automatic t_sref();
    ctl_u.set_mode(1'b0, 1'b0, 1'b1);
    ctl_u.cke(1'b0);
    ctl_u.set_mode(1'b0, 1'b0, 1'b0);
    ctl_u.set_odt(1'b1);
    ctl_u.cyc(8);
    chk("termOn sref", 1'b0, termOn);
    chk("powerDown sref", 1'b0, powerDown);
    ctl_u.set_odt(1'b0);
    ctl_u.cke(1'b1);
    ctl_u.cyc(8);
  endtask

  // Fall during a read burst; burst flags drop before the rise on purpose
  task automatic t_freset();
    ctl_u.set_cut(1'b1);
    // Clocks keep running through the reset delay
    ctl_u.cke(1'b0);
    chk("inReset forced", 1'b1, inReset);
    chk("contentsLost", 1'b1, contentsLost);
    ctl_u.set_cut(1'b0);
    ctl_u.pulse_init();
    chk("contentsLost ignored", 1'b1, contentsLost);
    ctl_u.cke(1'b1);
    chk("burstResume", 1'b1, burstResume);
    chk("inReset out", 1'b0, inReset);
    ctl_u.cyc(1);
    chk("burstResume pulse", 1'b0, burstResume);
    ctl_u.pulse_init();
    chk("contentsLost init", 1'b0, contentsLost);
    ctl_u.load(1'b1);
    relock();
    t_sync();
  endtask

  task automatic t_freq();
    ctl_u.freq_park();
    // New period stays inside the operating range
    halfPer = 15.0;
    ctl_u.cyc(3);
    ctl_u.cke(1'b1);
    chk("dllReady freq", 1'b0, dllReady);
    // Slot for the write-recovery reload, which reaches no port of this block
    ctl_u.cyc(1);
    relock();
    t_sync();
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    t_boot();
    t_enable();
    t_pd(1'b1, 1'b0, 1'b0);
    t_pd(1'b1, 1'b1, 1'b1);
    t_entry();
    t_pd(1'b0, 1'b0, 1'b1);
    relock();
    t_sref();
    t_freset();
    t_freq();
    finish_test();
  end
endmodule // psd_sequencer_tb
